// ===== shared/tpc_pkg.sv
// Constants for the three-phase input commutation decoder.
// Assumes a single 250 MHz logic clock; the clock period and dead-gap cycle counts derive from it.
package tpc_pkg;

  // Clock and sizes
  localparam int CLK_PERIOD_NS = 4;
  localparam int PHASES = 3;
  localparam int DT_SEL_W = 3;
  localparam int DT_CNT_W = 11;
  localparam int CODE_W = 4;

  // Programmable dead gap, in ns, per setting of the 3-bit selector
  localparam int DEAD_NS [8] = '{35, 52, 88, 440, 880, 1760, 3520, 5280};

  // Input mode setting as written by software; 2'h3 is reserved and ignored
  localparam logic [1:0] MODE_CODE_SIX = 2'h0;
  localparam logic [1:0] MODE_CODE_THREE = 2'h1;
  localparam logic [1:0] MODE_CODE_SINGLE = 2'h2;

  // Active decoder mode, one-hot
  typedef enum logic [2:0] {
    TPC_MODE_SIX = 3'h1,
    TPC_MODE_THREE = 3'h2,
    TPC_MODE_SINGLE = 3'h4
  } tpc_mode_t;

  // Reset value of every gate group
  localparam logic [2:0] GATES_OFF = 3'h0;

  // Commutation table fields: [5:3] phases C,B,A taking PWM; [2:0] low gates C,B,A on
  localparam int COMM_PWM_LSB = 3;
  localparam int COMM_LOW_LSB = 0;

  // Indexed by {a_low, b_high, b_low, dwell}
  localparam logic [5:0] COMM_TABLE [16] = '{
    6'h00, 6'h00, 6'h0C, 6'h1C, 6'h22, 6'h2A, 6'h0A, 6'h0E,
    6'h11, 6'h31, 6'h14, 6'h15, 6'h21, 6'h23, 6'h0E, 6'h0E
  };

  // Least time rounds up to whole cycles, never below one
  function automatic logic [DT_CNT_W-1:0] ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[DT_CNT_W-1:0];
  endfunction

endpackage

// ===== shared/tpc_gate_if.sv
// Request and gate bundle between the input decoder and the dead-gap stage.
// Both ends run on the same clock; no timing lives here.
`timescale 1ns/1ns
`default_nettype none
interface tpc_gate_if;
  import tpc_pkg::*;

  logic [PHASES-1:0] req_high;
  logic [PHASES-1:0] req_low;
  logic band_en;
  logic [DT_CNT_W-1:0] band_cycles;
  logic [PHASES-1:0] gate_high;
  logic [PHASES-1:0] gate_low;

  modport ctrl (
    output req_high,
    output req_low,
    output band_en,
    output band_cycles,
    input gate_high,
    input gate_low
  );

  modport band (
    input req_high,
    input req_low,
    input band_en,
    input band_cycles,
    output gate_high,
    output gate_low
  );
endinterface
`default_nettype wire

// ===== src/tpc_deadband.sv
// Gate output stage with optional dead gap between complementary commands.
// Assumes requests never ask for both gates of a phase at once.
`timescale 1ns/1ns
`default_nettype none
module tpc_deadband (
  input wire logic mclk,
  input wire logic rst_n,
  tpc_gate_if.band gif
);
  import tpc_pkg::*;

  genvar i;
  generate
    for (i = 0; i < PHASES; i++)
    begin : g_phase
      logic [1:0] out;
      logic [DT_CNT_W-1:0] cnt;
      logic [1:0] req;

      assign req = {gif.req_high[i], gif.req_low[i]};
      assign gif.gate_high[i] = out[1];
      assign gif.gate_low[i] = out[0];

      // Turn-off is immediate; turn-on waits out the gap after any gate was on
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          out <= 2'h0;
          cnt <= '0;
        end
        else if (!gif.band_en)
        begin
          out <= req;
          cnt <= '0;
        end
        else if (req != out)
        begin
          if (out != 2'h0)
          begin
            out <= 2'h0;
            cnt <= gif.band_cycles;
          end
          else if (cnt != '0)
          begin
            cnt <= cnt - 1'b1;
          end
          else
          begin
            out <= req;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== src/tpc_commutation.sv
// Input mode decoder for a three-phase half-bridge gate driver.
// Assumes pin inputs are asynchronous to mclk; mode, dead gap and
// freewheel settings come from configuration logic on mclk.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Six-input: high-only turns high gate, low-only low
// - Six-input: equal inputs hold both gates off
// - Three-input: high input alone sets complementary gates
// - Three-input: dead gap inserted between complementary gates
// - Three-input: low-side inputs are ignored
// - Single-PWM: PWM on A high, selector latched
// - Single-PWM: any duty from 0 to 100%
// - Selector decodes thirteen states including align, stop
// - Dwell high at change holds overlap until low
// - Single-PWM: phase C low input ignored
// - Freewheel setting picks active or diode mode
// - Active freewheel: low gate gets inverted PWM
// - Diode freewheel: low gate stays off
// - Six step codes map PWM, low, off phases
// - Overlap codes merge adjacent steps' gates
// - Align: PWM A, low B,C; stop: off
module tpc_commutation (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [tpc_pkg::PHASES-1:0] phase_high_input,
  input wire logic [tpc_pkg::PHASES-1:0] phase_low_input,
  input wire logic [1:0] input_mode,
  input wire logic freewheel_select,
  input wire logic [tpc_pkg::DT_SEL_W-1:0] dead_gap,
  output logic [tpc_pkg::PHASES-1:0] high_gate_out,
  output logic [tpc_pkg::PHASES-1:0] low_gate_out
);
  import tpc_pkg::*;

  // Synchroniser stages; the first stage feeds only the second
  logic [PHASES-1:0] hi_meta;
  logic [PHASES-1:0] hi_sync;
  logic [PHASES-1:0] lo_meta;
  logic [PHASES-1:0] lo_sync;

  // Registered input levels seen by the decoder
  logic [PHASES-1:0] h_q;
  logic [PHASES-1:0] l_q;

  tpc_mode_t mode;
  tpc_mode_t next_mode;

  tpc_gate_if gif ();

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_meta <= GATES_OFF;
      hi_sync <= GATES_OFF;
      lo_meta <= GATES_OFF;
      lo_sync <= GATES_OFF;
    end
    else
    begin
      hi_meta <= phase_high_input;
      hi_sync <= hi_meta;
      lo_meta <= phase_low_input;
      lo_sync <= lo_meta;
    end
  end

  // Decoder stage; in single-PWM mode this is the selector latch
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      h_q <= GATES_OFF;
      l_q <= GATES_OFF;
    end
    else
    begin
      h_q <= hi_sync;
      l_q <= lo_sync;
    end
  end

  // Mode selection: a reserved setting keeps the current mode
  logic gates_idle;
  assign gates_idle = (high_gate_out == GATES_OFF) && (low_gate_out == GATES_OFF);
  assign next_mode = (input_mode == MODE_CODE_SIX) ? TPC_MODE_SIX :
                     (input_mode == MODE_CODE_THREE) ? TPC_MODE_THREE :
                     (input_mode == MODE_CODE_SINGLE) ? TPC_MODE_SINGLE : mode;

  // Switching modes with a gate on could glitch a half-bridge, so wait
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= TPC_MODE_SIX;
    end
    else if (gates_idle)
    begin
      mode <= next_mode;
    end
  end

  // Six-input decode: only exclusive patterns drive a gate
  logic [PHASES-1:0] six_high;
  logic [PHASES-1:0] six_low;
  assign six_high = h_q & ~l_q;
  assign six_low = l_q & ~h_q;

  // Three-input decode: low pins unread, low side is the complement
  logic [PHASES-1:0] three_high;
  logic [PHASES-1:0] three_low;
  assign three_high = h_q;
  assign three_low = ~h_q;

  // Single-PWM decode; phase C low is never read here
  logic pwm;
  logic [CODE_W-1:0] code;
  logic [5:0] comm;
  logic [PHASES-1:0] pwm_on;
  logic [PHASES-1:0] low_on;
  logic [PHASES-1:0] fw_low;
  logic [PHASES-1:0] one_high;
  logic [PHASES-1:0] one_low;
  assign pwm = h_q[0];
  assign code = {l_q[0], h_q[1], l_q[1], h_q[2]};
  assign comm = COMM_TABLE[code];
  assign pwm_on = comm[COMM_PWM_LSB +: PHASES];
  assign low_on = comm[COMM_LOW_LSB +: PHASES];
  // PWM passes unfiltered, so full and zero duty are both honoured
  assign one_high = pwm_on & {PHASES{pwm}};
  assign fw_low = freewheel_select ? (pwm_on & {PHASES{~pwm}}) : GATES_OFF;
  assign one_low = low_on | fw_low;

  // Request selection per active mode
  assign gif.req_high = (mode == TPC_MODE_SINGLE) ? one_high :
                        (mode == TPC_MODE_THREE) ? three_high : six_high;
  assign gif.req_low = (mode == TPC_MODE_SINGLE) ? one_low :
                       (mode == TPC_MODE_THREE) ? three_low : six_low;
  // Dead gap only in three-input mode; the active-freewheel low gate gets none
  assign gif.band_en = (mode == TPC_MODE_THREE);
  assign gif.band_cycles = ns_to_cycles(DEAD_NS[dead_gap]);

  tpc_deadband u_band (
    .mclk(mclk),
    .rst_n(rst_n),
    .gif(gif)
  );

  // Gate outputs are the output-stage flops
  assign high_gate_out = gif.gate_high;
  assign low_gate_out = gif.gate_low;

  // Checks

  property p_six_drive;
    @(posedge mclk) disable iff (!rst_n)
    (mode == TPC_MODE_SIX && h_q[0] && !l_q[0]) |=> (high_gate_out[0] && !low_gate_out[0]);
  endproperty
  a_six_drive: assert property (p_six_drive)
    else $error("six-input high request did not drive high gate only");

  property p_six_equal_off;
    @(posedge mclk) disable iff (!rst_n)
    (mode == TPC_MODE_SIX && h_q[1] == l_q[1]) |=> (!high_gate_out[1] && !low_gate_out[1]);
  endproperty
  a_six_equal_off: assert property (p_six_equal_off)
    else $error("six-input equal inputs did not hold phase off");

  property p_three_high;
    @(posedge mclk) disable iff (!rst_n)
    (mode == TPC_MODE_THREE && h_q[0]) |=> !low_gate_out[0];
  endproperty
  a_three_high: assert property (p_three_high)
    else $error("three-input high request left low gate on");

  property p_three_low;
    @(posedge mclk) disable iff (!rst_n)
    (mode == TPC_MODE_THREE && !h_q[2]) |=> !high_gate_out[2];
  endproperty
  a_three_low: assert property (p_three_low)
    else $error("three-input low request left high gate on");

  sequence s_low_drop;
    mode == TPC_MODE_THREE && $fell(low_gate_out[0]);
  endsequence

  sequence s_high_held_off;
    (!high_gate_out[0] || mode != TPC_MODE_THREE) [*8];
  endsequence

  property p_dead_gap;
    @(posedge mclk) disable iff (!rst_n)
    s_low_drop |=> s_high_held_off;
  endproperty
  a_dead_gap: assert property (p_dead_gap)
    else $error("high gate turned on inside the dead gap");

  property p_active_fw;
    @(posedge mclk) disable iff (!rst_n)
    (mode == TPC_MODE_SINGLE && freewheel_select && pwm_on[0])
      |=> (low_gate_out[0] == !$past(h_q[0]));
  endproperty
  a_active_fw: assert property (p_active_fw)
    else $error("active freewheel low gate not inverse of PWM");

  property p_diode_fw;
    @(posedge mclk) disable iff (!rst_n)
    (mode == TPC_MODE_SINGLE && !freewheel_select && pwm_on[1]) |=> !low_gate_out[1];
  endproperty
  a_diode_fw: assert property (p_diode_fw)
    else $error("diode freewheel low gate driven");

  property p_step_ab;
    @(posedge mclk) disable iff (!rst_n)
    (mode == TPC_MODE_SINGLE && code == 4'h6)
      |=> (high_gate_out[0] == $past(h_q[0]) && low_gate_out[1]
           && !high_gate_out[2] && !low_gate_out[2] && !high_gate_out[1]);
  endproperty
  a_step_ab: assert property (p_step_ab)
    else $error("step AB gates wrong");

  property p_overlap_ab_cb;
    @(posedge mclk) disable iff (!rst_n)
    (mode == TPC_MODE_SINGLE && code == 4'h5)
      |=> (high_gate_out[0] == $past(h_q[0]) && high_gate_out[2] == $past(h_q[0])
           && low_gate_out[1]);
  endproperty
  a_overlap_ab_cb: assert property (p_overlap_ab_cb)
    else $error("overlap AB_CB gates wrong");

  property p_stop;
    @(posedge mclk) disable iff (!rst_n)
    (mode == TPC_MODE_SINGLE && code == 4'h0)
      |=> (high_gate_out == GATES_OFF && low_gate_out == GATES_OFF);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop state left a gate on");

  property p_mode_when_idle;
    @(posedge mclk) disable iff (!rst_n)
    $changed(mode) |-> ($past(high_gate_out) == GATES_OFF && $past(low_gate_out) == GATES_OFF);
  endproperty
  a_mode_when_idle: assert property (p_mode_when_idle)
    else $error("mode changed while a gate was on");

endmodule
`default_nettype wire

// ===== dv/tpc_host_model.sv
// Host model: drives the decoder's pin inputs at the falling edge.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ns
`default_nettype none
module tpc_host_model (
  input wire logic mclk,
  output logic [2:0] phase_high_input,
  output logic [2:0] phase_low_input
);
  // Pins idle low, so the dwell input starts low as well
  initial
  begin
    phase_high_input = 3'h0;
    phase_low_input = 3'h0;
  end

  // Raw pin levels for the six- and three-input modes
  task automatic put_pins(input logic [2:0] hi, input logic [2:0] lo);
    @(negedge mclk);
    phase_high_input = hi;
    phase_low_input = lo;
  endtask

  // Dwell follows code bit 0, so it is high for overlap codes and for codes 1, 7 and F
  task automatic put_step(input logic [3:0] code, input logic pwm, input logic c_low);
    @(negedge mclk);
    phase_high_input = {code[0], code[2], pwm};
    phase_low_input = {c_low, code[1], code[3]};
  endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the commutation decoder with a host pin model.
// Assumes a four-edge pin-to-gate latency and mode changes only while gates are off.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tpc_pkg::*;
  typedef struct {int cyc; logic [5:0] exp;} tpc_note_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] input_mode = 2'h0;
  logic freewheel_select = 1'b0;
  logic [2:0] dead_gap = 3'h0;
  wire logic [2:0] phase_high_input;
  wire logic [2:0] phase_low_input;
  logic [2:0] high_gate_out;
  logic [2:0] low_gate_out;
  tpc_note_t notes[$];
  int cycle_cnt = 0;
  int fail_count = 0;
  int samples_checked = 0;
  int g;
  logic a_lvl;
  logic pwm;
  logic [5:0] e;

  always #2 mclk = ~mclk;

  tpc_commutation dut_u (
    .mclk(mclk),
    .rst_n(rst_n),
    .phase_high_input(phase_high_input),
    .phase_low_input(phase_low_input),
    .input_mode(input_mode),
    .freewheel_select(freewheel_select),
    .dead_gap(dead_gap),
    .high_gate_out(high_gate_out),
    .low_gate_out(low_gate_out)
  );

  tpc_host_model host_u (
    .mclk(mclk),
    .phase_high_input(phase_high_input),
    .phase_low_input(phase_low_input)
  );

  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Note a gate pattern due a fixed number of cycles from now
  task automatic note(input int dly, input logic [2:0] hg, input logic [2:0] lg);
    notes.push_back('{cycle_cnt + dly, {hg, lg}});
  endtask

  // Step table kept apart from the design: {PWM phases C..A, low gates C..A}
  function automatic logic [5:0] step_gates(input logic [3:0] c);
    case (c)
      4'h6: return 6'h0A;
      4'h5: return 6'h2A;
      4'h4: return 6'h22;
      4'hD: return 6'h23;
      4'hC: return 6'h21;
      4'h9: return 6'h31;
      4'h8: return 6'h11;
      4'hB: return 6'h15;
      4'hA: return 6'h14;
      4'h3: return 6'h1C;
      4'h2: return 6'h0C;
      4'h7, 4'hE, 4'hF: return 6'h0E;
      default: return 6'h00;
    endcase
  endfunction

  // Scoreboard: the oldest note is compared in the cycle it falls due
  always @(negedge mclk)
  begin
    if (notes.size() > 0 && notes[0].cyc == cycle_cnt)
    begin
      check({high_gate_out, low_gate_out}, notes[0].exp);
      void'(notes.pop_front());
    end
  end

  // Hang guard, well above the longest dead-gap sweep
  always @(posedge mclk)
  begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 10000)
    begin
      fail_count++;
      end_sim();
    end
  end

  initial
  begin
    void'($urandom(59561));
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    // Six-input: every pin combination, one per cycle
    for (int i = 0; i < 64; i++)
    begin
      host_u.put_pins(i[5:3], i[2:0]);
      note(4, i[5:3] & ~i[2:0], i[2:0] & ~i[5:3]);
    end
    host_u.put_pins(3'h0, 3'h0);
    repeat (6) @(negedge mclk);
    input_mode = MODE_CODE_SINGLE;
    // Single-PWM: every code under both freewheel kinds, random duty
    for (int fw = 0; fw < 2; fw++)
    begin
      repeat (6) @(negedge mclk);
      freewheel_select = fw[0];
      repeat (4) @(negedge mclk);
      for (int c = 0; c < 16; c++)
      begin
        repeat (6)
        begin
          pwm = 1'($urandom);
          e = step_gates(c[3:0]);
          host_u.put_step(c[3:0], pwm, 1'($urandom));
          note(4, pwm ? e[5:3] : 3'h0, e[2:0] | ((fw[0] && !pwm) ? e[5:3] : 3'h0));
        end
      end
    end
    host_u.put_step(4'h0, 1'b0, 1'b0);
    repeat (6) @(negedge mclk);
    input_mode = MODE_CODE_THREE;
    repeat (6) @(negedge mclk);
    // Three-input: toggle phase A under every dead-gap setting
    host_u.put_pins(3'h7, 3'($urandom));
    note(14, 3'h7, 3'h0);
    repeat (16) host_u.put_pins(3'h7, 3'($urandom));
    for (int s = 0; s < 8; s++)
    begin
      a_lvl = s[0];
      dead_gap = s[2:0];
      g = (DEAD_NS[s] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      host_u.put_pins({2'h3, a_lvl}, 3'($urandom));
      note(4, 3'h6, 3'h0);
      note(4 + g, 3'h6, 3'h0);
      note(5 + g, {2'h3, a_lvl}, {2'h0, ~a_lvl});
      repeat (g + 7) host_u.put_pins({2'h3, a_lvl}, 3'($urandom));
    end
    // Mode request while gates are on must not take effect
    input_mode = MODE_CODE_SIX;
    repeat (6)
    begin
      host_u.put_pins(3'h7, 3'h7);
      note(4, 3'h7, 3'h0);
    end
    repeat (8) @(negedge mclk);
    end_sim();
  end
endmodule
`default_nettype wire
